/* File: hdl/cwd_pkg.sv */
/*
  constants for the countdown watchdog: register offsets, field layout,
  reset values, step selection codes and oscillator divider widths.
  assumes a 32.768 khz oscillator and an 8-bit register port.
*/
package cwd_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_EN_A = 8'h29;  // irq_enable_a_reg
  localparam logic [7:0] ADDR_IRQ_EN_B = 8'h2a;  // irq_enable_b_reg
  localparam logic [7:0] ADDR_WDOG     = 8'h2d;  // watchdog_control_count

  // ----------------------------------------------------------------
  // field layout of watchdog_control_count
  // ----------------------------------------------------------------
  localparam int MODE_BIT  = 7;  // repeat_select
  localparam int CNT_MSB   = 6;  // countdown_value
  localparam int CNT_LSB   = 2;
  localparam int STEP_MSB  = 1;  // step_select
  localparam int STEP_LSB  = 0;
  localparam int CNT_W     = CNT_MSB - CNT_LSB + 1;
  // expiry enable bit inside each irq enable register
  localparam int IRQ_EN_BIT = 0;

  // ----------------------------------------------------------------
  // reset values and count constants
  // ----------------------------------------------------------------
  localparam logic [7:0]       RDATA_RESET = 8'h00;
  localparam logic             MODE_RESET  = 1'b0;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE     = 5'h01;

  // step sizes
  typedef enum logic [1:0] {
    STEP_4S        = 2'h0,
    STEP_1S        = 2'h1,
    STEP_QUARTER   = 2'h2,
    STEP_SIXTEENTH = 2'h3
  } cwd_step_type;

  // ----------------------------------------------------------------
  // oscillator divider: step = 2**bits oscillator edges
  // ----------------------------------------------------------------
  localparam int OSC_HZ        = 32768;
  localparam int DIV_BITS_4S   = $clog2(OSC_HZ * 4);
  localparam int DIV_BITS_1S   = $clog2(OSC_HZ);
  localparam int DIV_BITS_QTR  = $clog2(OSC_HZ / 4);
  localparam int DIV_BITS_16TH = $clog2(OSC_HZ / 16);
  localparam int PRESC_W       = DIV_BITS_4S;

  // interrupt pulse counter: width in bits, pulse length in oscillator edges
  localparam int            PULSE_W     = 4;
  localparam logic [3:0]    PULSE_TICKS = 4'h8;
  localparam logic [3:0]    PULSE_ONE   = 4'h1;
  localparam logic [3:0]    PULSE_ZERO  = 4'h0;

endpackage : cwd_pkg

/* File: hdl/cwd_irq_pin.sv */
/*
  one interrupt pin driver for the watchdog expiry event.
  assumes expiry and flag come from the same clock domain and that the
  oscillator tick is a one-cycle enable.
*/
`timescale 1ns/1ps
`default_nettype none

module cwd_irq_pin (
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  input  wire logic i_enable,
  input  wire logic i_pulse_mode,
  input  wire logic i_expiry,
  input  wire logic i_flag,
  input  wire logic i_osc_tick,
  output logic      o_irq_n
);

  // ----------------------------------------------------------------
  // pulse stretch and pin register
  // ----------------------------------------------------------------
  logic [cwd_pkg::PULSE_W-1:0] pulse_cnt_q;
  logic                        pulse_act;
  logic                        irq_act;

  assign pulse_act = (pulse_cnt_q != cwd_pkg::PULSE_ZERO);
  // level mode follows the flag; pulse mode ignores it
  assign irq_act   = i_enable & (i_pulse_mode ? (pulse_act | i_expiry) : i_flag);

  // a new expiry restarts the pulse even with the flag still set
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      pulse_cnt_q <= cwd_pkg::PULSE_ZERO;
      o_irq_n     <= 1'b1;
    end else begin
      if (i_expiry) begin
        pulse_cnt_q <= cwd_pkg::PULSE_TICKS;
      end else if (i_osc_tick && pulse_act) begin
        pulse_cnt_q <= pulse_cnt_q - cwd_pkg::PULSE_ONE;
      end
      o_irq_n <= ~irq_act;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_level_tracks_flag;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_enable && !i_pulse_mode) |=> (o_irq_n == !$past(i_flag));
  endproperty
  a_level_tracks_flag: assert property (p_level_tracks_flag)
    else $error("level irq pin does not follow expiry flag");

  property p_pulse_each_expiry;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_enable && i_pulse_mode && i_expiry && $stable(i_enable) && $stable(i_pulse_mode))
        |=> !o_irq_n ##1 !o_irq_n;
  endproperty
  a_pulse_each_expiry: assert property (p_pulse_each_expiry)
    else $error("pulse irq pin missed an expiry");

  property p_disabled_quiet;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      !i_enable |=> o_irq_n;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled irq pin went active");

endmodule : cwd_irq_pin

`default_nettype wire

/* File: hdl/cwd_watchdog.sv */
/*
  countdown watchdog: 5-bit down counter stepped from the 32.768 khz
  oscillator, single shot or repeat, sticky expiry flag, two irq pins.
  assumes the oscillator arrives as a free-running pin level, a byte
  register port on the system clock, and a one-cycle clear command.
*/
`timescale 1ns/1ps
`default_nettype none

module cwd_watchdog (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_osc_32k,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  input  wire logic       i_clear_expiry,
  input  wire logic       i_irq_pulse_mode_a,
  input  wire logic       i_irq_pulse_mode_b,
  output logic            o_expiry_flag,
  output logic            o_irq_pin_a_n,
  output logic            o_irq_pin_b_n
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [cwd_pkg::PRESC_W-1:0] PRESC_ONE = {{(cwd_pkg::PRESC_W-1){1'b0}}, 1'b1};

  logic                            osc_s1_q;
  logic                            osc_s2_q;
  logic                            osc_s3_q;
  logic                            osc_lvl_q;
  logic                            osc_agree;
  logic                            osc_tick;

  logic [cwd_pkg::PRESC_W-1:0]     presc_q;
  logic                            step_due;

  logic                            mode_q;
  cwd_pkg::cwd_step_type           step_q;
  logic [cwd_pkg::CNT_W-1:0]       reload_q;
  logic [cwd_pkg::CNT_W-1:0]       count_q;
  logic                            load_pend_q;
  logic                            load_ack;
  logic                            count_live;
  logic                            expire;
  logic                            flag_q;

  logic                            irq_en_a_q;
  logic                            irq_en_b_q;

  logic                            wr_wdog;
  logic                            wr_en_a;
  logic                            wr_en_b;
  logic                            rd_hit_wdog;
  logic                            rd_hit_en_a;
  logic                            rd_hit_en_b;
  logic [7:0]                      rd_wdog_word;
  logic [7:0]                      rd_en_word_a;
  logic [7:0]                      rd_en_word_b;
  logic [7:0]                      rd_mux;

  // ----------------------------------------------------------------
  // oscillator pin synchroniser
  // ----------------------------------------------------------------
  // three stages; a level change is believed only once stages two and
  // three agree, so a metastable first stage never reaches the counter
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      osc_s1_q  <= 1'b0;
      osc_s2_q  <= 1'b0;
      osc_s3_q  <= 1'b0;
      osc_lvl_q <= 1'b0;
    end else begin
      osc_s1_q <= i_osc_32k;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      if (osc_agree) begin
        osc_lvl_q <= osc_s3_q;
      end
    end
  end

  // one-cycle enable on each accepted rising oscillator edge
  assign osc_agree = (osc_s2_q == osc_s3_q);
  assign osc_tick  = osc_agree & osc_s3_q & ~osc_lvl_q;

  // ----------------------------------------------------------------
  // step prescaler
  // ----------------------------------------------------------------
  // free running so that periods after the first are exact; a load
  // lands at an arbitrary phase, hence the one-step first-period error
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      presc_q <= '0;
    end else if (osc_tick) begin
      presc_q <= presc_q + PRESC_ONE;
    end
  end

  // step strobe: low divider bits all ones on an oscillator edge
  assign step_due = osc_tick & (
    (step_q == cwd_pkg::STEP_4S)      ? (&presc_q[cwd_pkg::DIV_BITS_4S-1:0])   :
    (step_q == cwd_pkg::STEP_1S)      ? (&presc_q[cwd_pkg::DIV_BITS_1S-1:0])   :
    (step_q == cwd_pkg::STEP_QUARTER) ? (&presc_q[cwd_pkg::DIV_BITS_QTR-1:0])  :
                                        (&presc_q[cwd_pkg::DIV_BITS_16TH-1:0]));

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign wr_wdog     = i_reg_wr & (i_reg_addr == cwd_pkg::ADDR_WDOG);
  assign wr_en_a     = i_reg_wr & (i_reg_addr == cwd_pkg::ADDR_IRQ_EN_A);
  assign wr_en_b     = i_reg_wr & (i_reg_addr == cwd_pkg::ADDR_IRQ_EN_B);
  assign rd_hit_wdog = (i_reg_addr == cwd_pkg::ADDR_WDOG);
  assign rd_hit_en_a = (i_reg_addr == cwd_pkg::ADDR_IRQ_EN_A);
  assign rd_hit_en_b = (i_reg_addr == cwd_pkg::ADDR_IRQ_EN_B);

  // ----------------------------------------------------------------
  // control fields and load handshake
  // ----------------------------------------------------------------
  // the write is parked in reload_q and a request flag; the counter
  // takes the whole word only on an oscillator edge, never half of it
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      mode_q      <= cwd_pkg::MODE_RESET;
      step_q      <= cwd_pkg::STEP_4S;
      reload_q    <= cwd_pkg::CNT_ZERO;
      load_pend_q <= 1'b0;
    end else begin
      if (wr_wdog) begin
        mode_q      <= i_reg_wdata[cwd_pkg::MODE_BIT];
        step_q      <= cwd_pkg::cwd_step_type'(i_reg_wdata[cwd_pkg::STEP_MSB:cwd_pkg::STEP_LSB]);
        reload_q    <= i_reg_wdata[cwd_pkg::CNT_MSB:cwd_pkg::CNT_LSB];
        load_pend_q <= 1'b1;
      end else if (load_ack) begin
        load_pend_q <= 1'b0;
      end
    end
  end

  // the handover is acknowledged on the next oscillator edge
  assign load_ack = load_pend_q & osc_tick;

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  // a count of zero is stopped: no step, no expiry, no new interrupt
  assign count_live = (count_q != cwd_pkg::CNT_ZERO);
  assign expire     = step_due & ~load_ack & (count_q == cwd_pkg::CNT_ONE);

  // a pending load beats the step in the same cycle, so a mid-period
  // write replaces the running value rather than racing it
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      count_q <= cwd_pkg::CNT_ZERO;
    end else if (load_ack) begin
      count_q <= reload_q;
    end else if (expire) begin
      count_q <= mode_q ? reload_q : cwd_pkg::CNT_ZERO;
    end else if (step_due && count_live) begin
      count_q <= count_q - cwd_pkg::CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // expiry flag
  // ----------------------------------------------------------------
  // an expiry in the clearing cycle wins, so no period end is lost
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= expire | (flag_q & ~i_clear_expiry);
    end
  end

  assign o_expiry_flag = flag_q;

  // ----------------------------------------------------------------
  // interrupt enables
  // ----------------------------------------------------------------
  // only the expiry enable bit is held; other bits belong elsewhere
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      irq_en_a_q <= 1'b0;
      irq_en_b_q <= 1'b0;
    end else begin
      if (wr_en_a) begin
        irq_en_a_q <= i_reg_wdata[cwd_pkg::IRQ_EN_BIT];
      end
      if (wr_en_b) begin
        irq_en_b_q <= i_reg_wdata[cwd_pkg::IRQ_EN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  // count field shows the live counter; it keeps running during the
  // read, so software must compare two reads
  assign rd_wdog_word = {mode_q, count_q, step_q};
  assign rd_en_word_a = {7'h00, irq_en_a_q};
  assign rd_en_word_b = {7'h00, irq_en_b_q};
  assign rd_mux = rd_hit_wdog ? rd_wdog_word :
                  rd_hit_en_a ? rd_en_word_a :
                  rd_hit_en_b ? rd_en_word_b : cwd_pkg::RDATA_RESET;

  // read data registered; unmapped offsets return zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_reg_rdata <= cwd_pkg::RDATA_RESET;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // interrupt pins
  // ----------------------------------------------------------------
  cwd_irq_pin u_irq_a (
    .i_sys_clk    (i_sys_clk),
    .i_reset_n    (i_reset_n),
    .i_enable     (irq_en_a_q),
    .i_pulse_mode (i_irq_pulse_mode_a),
    .i_expiry     (expire),
    .i_flag       (flag_q),
    .i_osc_tick   (osc_tick),
    .o_irq_n      (o_irq_pin_a_n)
  );

  cwd_irq_pin u_irq_b (
    .i_sys_clk    (i_sys_clk),
    .i_reset_n    (i_reset_n),
    .i_enable     (irq_en_b_q),
    .i_pulse_mode (i_irq_pulse_mode_b),
    .i_expiry     (expire),
    .i_flag       (flag_q),
    .i_osc_tick   (osc_tick),
    .o_irq_n      (o_irq_pin_b_n)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_decrement;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (step_due && !load_ack && count_q > cwd_pkg::CNT_ONE)
        |=> (count_q == $past(count_q) - cwd_pkg::CNT_ONE);
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counter did not step down by one");

  property p_zero_stays;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (!count_live && !load_pend_q && !wr_wdog) |=> (!count_live && !expire);
  endproperty
  a_zero_stays: assert property (p_zero_stays)
    else $error("stopped watchdog moved");

  property p_load_replaces;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      load_ack |=> (count_q == $past(reload_q));
  endproperty
  a_load_replaces: assert property (p_load_replaces)
    else $error("write did not replace the running count");

  property p_load_bounded;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (load_pend_q && osc_tick && !wr_wdog) |=> !load_pend_q;
  endproperty
  a_load_bounded: assert property (p_load_bounded)
    else $error("count load never handed over");

  property p_repeat_reload;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (expire && mode_q) |=> (count_q == $past(reload_q)) && flag_q;
  endproperty
  a_repeat_reload: assert property (p_repeat_reload)
    else $error("repeat mode did not reload and flag");

  property p_single_stop;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (expire && !mode_q) |=> (count_q == cwd_pkg::CNT_ZERO) && flag_q;
  endproperty
  a_single_stop: assert property (p_single_stop)
    else $error("single shot did not stop at zero with flag");

  property p_flag_sticky;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (flag_q && !i_clear_expiry) |=> flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("expiry flag dropped without clear");

  property p_read_live;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_reg_rd && rd_hit_wdog)
        |=> (o_reg_rdata[cwd_pkg::CNT_MSB:cwd_pkg::CNT_LSB] == $past(count_q));
  endproperty
  a_read_live: assert property (p_read_live)
    else $error("read did not return the live count");

  property p_reset_zero;
    @(posedge i_sys_clk)
      !i_reset_n |=> (o_reg_rdata == cwd_pkg::RDATA_RESET) && !flag_q && !mode_q &&
                     (count_q == cwd_pkg::CNT_ZERO) && o_irq_pin_a_n && o_irq_pin_b_n;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("reset did not clear the watchdog state");

  property p_clear_drops;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_clear_expiry && !expire) |=> !flag_q;
  endproperty
  a_clear_drops: assert property (p_clear_drops)
    else $error("clear command left the expiry flag set");

  property p_zero_load_stops;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (load_ack && (reload_q == cwd_pkg::CNT_ZERO)) |=> !count_live;
  endproperty
  a_zero_load_stops: assert property (p_zero_load_stops)
    else $error("zero load did not stop the watchdog");

endmodule : cwd_watchdog

`default_nettype wire

/* File: testbench/cwd_host_model.sv */
/*
  host side of the watchdog register port: byte writes, reads and a
  double read that retries up to four pairs for two matching values.
  assumes one calling process and the system clock of the watchdog.
*/
`timescale 1ns/1ps
`default_nettype none

module cwd_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // idle lines show the inverse of the last value, not a stale copy
  initial begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1 o_addr = a;
    o_wdata = d;
    o_wr    = 1'b1;
    @(posedge i_sys_clk);
    #1 o_wr = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask : wr

  // data is taken a full cycle after the strobe, while it still stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    #1 o_addr = a;
    o_rd = 1'b1;
    @(posedge i_sys_clk);
    #1 o_rd = 1'b0;
    o_addr = ~a;
    @(posedge i_sys_clk);
    #1 d = i_rdata;
  endtask : rd

  // the count keeps moving during reads: retry up to four pairs, else keep the last read
  task automatic rd2(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] x;
    logic [7:0] y;
    y = 8'h00;
    for (int i = 0; i < 4; i++) begin
      rd(a, x);
      rd(a, y);
      if (x === y) break;
    end
    d = y;
  endtask : rd2
endmodule : cwd_host_model

`default_nettype wire

/* File: testbench/testbench.sv */
/*
  self-checking bench for the countdown watchdog: reset values, field
  layout, enables, repeat and single shot expiry, pulse and level pins.
  assumes a fast oscillator of 8 system cycles, so one 1/16 s step
  lasts 2048 oscillator edges, 16384 system cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic       sys_clk;
  logic       reset_n;
  logic       osc;
  logic [7:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       clr;
  logic       pm_a;
  logic       pm_b;
  logic       flag;
  logic       pin_a_n;
  logic       pin_b_n;
  logic [7:0] d;
  logic       hit;
  logic [7:0] a;
  logic [31:0] rng;
  int         bad_count;
  int         checks;
  int         cyc;
  int         t0;

  cwd_watchdog cwd_watchdog_i (
    .i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_osc_32k(osc),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_clear_expiry(clr), .i_irq_pulse_mode_a(pm_a),
    .i_irq_pulse_mode_b(pm_b), .o_expiry_flag(flag),
    .o_irq_pin_a_n(pin_a_n), .o_irq_pin_b_n(pin_b_n));

  cwd_host_model cwd_host_model_i (
    .i_sys_clk(sys_clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_wdata(wdata));

  // ----------------------------------------------------------------
  // clocks and helpers
  // ----------------------------------------------------------------
  // oscillator far faster than real, so a step fits in the run
  always #10 sys_clk = ~sys_clk;
  always #80 osc = ~osc;
  always @(posedge sys_clk) cyc <= cyc + 1;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  function automatic logic [7:0] wd(input logic m, input logic [4:0] c,
                                    input logic [1:0] s);
    return {m, c, s};
  endfunction : wd

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // bounded wait for pin a to go low
  task automatic wait_fall(input int bound, output logic h);
    h = 1'b0;
    for (int i = 0; i < bound && !h; i++) begin
      @(posedge sys_clk);
      #1 h = (pin_a_n === 1'b0);
    end
  endtask : wait_fall

  task automatic clear_flag;
    @(posedge sys_clk);
    #1 clr = 1'b1;
    @(posedge sys_clk);
    #1 clr = 1'b0;
    @(posedge sys_clk);
    #1 chk({7'h00, flag}, 8'h00);
  endtask : clear_flag

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    osc = 1'b0;
    reset_n = 1'b0;
    clr = 1'b0;
    pm_a = 1'b1;
    pm_b = 1'b0;
    rng = 32'h00000033;
    bad_count = 0;
    checks = 0;
    cyc = 0;
    repeat (4) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    chk({6'h00, pin_a_n, pin_b_n}, 8'h03);
    chk({7'h00, flag}, 8'h00);
    for (int j = 0; j < 3; j++) begin
      cwd_host_model_i.rd(j == 0 ? 8'h29 : j == 1 ? 8'h2a : 8'h2d, d);
      chk(d, 8'h00);
    end
    // unmapped place: write ignored, read gives zero
    rng = xs(rng);
    a = (rng[7:0] inside {8'h29, 8'h2a, 8'h2d}) ? 8'h00 : rng[7:0];
    cwd_host_model_i.wr(a, rng[15:8]);
    cwd_host_model_i.rd(a, d);
    chk(d, 8'h00);
    // every mode and step code with a stopped counter
    for (int k = 0; k < 8; k++) begin
      cwd_host_model_i.wr(8'h2d, wd(k[2], 5'h00, k[1:0]));
      cwd_host_model_i.rd(8'h2d, d);
      chk(d, wd(k[2], 5'h00, k[1:0]));
    end
    // enables hold bit 0 only
    for (int j = 0; j < 2; j++) begin
      rng = xs(rng);
      cwd_host_model_i.wr(j == 0 ? 8'h29 : 8'h2a, rng[7:0] | 8'h01);
      cwd_host_model_i.rd(j == 0 ? 8'h29 : 8'h2a, d);
      chk(d, 8'h01);
    end
    // repeat mode, count 1, 1/16 s steps
    cwd_host_model_i.wr(8'h2d, wd(1'b1, 5'h01, 2'h3));
    wait_fall(20000, hit);
    chk({7'h00, hit}, 8'h01);
    t0 = cyc;
    repeat (2) @(posedge sys_clk);
    #1 chk({6'h00, flag, pin_b_n}, 8'h02);
    repeat (38) @(posedge sys_clk);
    #1 chk({7'h00, pin_a_n}, 8'h00);
    repeat (40) @(posedge sys_clk);
    #1 chk({7'h00, pin_a_n}, 8'h01);
    cwd_host_model_i.rd2(8'h2d, d);
    chk(d, wd(1'b1, 5'h01, 2'h3));
    // second pulse with the flag still set, one exact step later
    wait_fall(17000, hit);
    chk({7'h00, hit}, 8'h01);
    chk({7'h00, cyc - t0 >= 16383 && cyc - t0 <= 16385}, 8'h01);
    chk({7'h00, flag}, 8'h01);
    repeat (80) @(posedge sys_clk);
    // replace the running count, then stop with zero
    cwd_host_model_i.wr(8'h2d, wd(1'b1, 5'h1f, 2'h3));
    repeat (40) @(posedge sys_clk);
    cwd_host_model_i.rd2(8'h2d, d);
    chk(d, wd(1'b1, 5'h1f, 2'h3));
    cwd_host_model_i.wr(8'h2d, wd(1'b1, 5'h00, 2'h3));
    repeat (40) @(posedge sys_clk);
    cwd_host_model_i.rd2(8'h2d, d);
    chk(d, wd(1'b1, 5'h00, 2'h3));
    clear_flag();
    @(posedge sys_clk);
    #1 chk({7'h00, pin_b_n}, 8'h01);
    // single shot with pin b disabled
    rng = xs(rng);
    cwd_host_model_i.wr(8'h2a, rng[7:0] & 8'hfe);
    cwd_host_model_i.wr(8'h2d, wd(1'b0, 5'h01, 2'h3));
    wait_fall(20000, hit);
    chk({7'h00, hit}, 8'h01);
    repeat (3) @(posedge sys_clk);
    #1 chk({6'h00, flag, pin_b_n}, 8'h03);
    repeat (80) @(posedge sys_clk);
    cwd_host_model_i.rd2(8'h2d, d);
    chk(d, wd(1'b0, 5'h00, 2'h3));
    clear_flag();
    // a stopped single shot must not expire again
    wait_fall(17000, hit);
    chk({7'h00, hit}, 8'h00);
    chk({7'h00, flag}, 8'h00);
    close_out();
  end
endmodule : testbench

`default_nettype wire
